// [logic/blc_defs.svh]
// Register map, field positions, reset values and timing constants
`ifndef BLC_DEFS_SVH
`define BLC_DEFS_SVH
`define BLC_AW 8
`define BLC_DW 32
`define BLC_REG_CTRL 8'h00
`define BLC_REG_BRT 8'h04
`define BLC_REG_CUR0 8'h08
`define BLC_REG_CUR5 8'h1C
`define BLC_REG_STAT 8'h20
`define BLC_NCH 6
`define BLC_F_SPAN 1:0
`define BLC_F_RATE 3:2
`define BLC_F_BSRC 4
`define BLC_CTRL_RST 5'h02
`define BLC_CUR_RST 12'hFFF
`define BLC_BRT_RST 16'hFFFF
`define BLC_S_OVPH 0
`define BLC_S_EXT 1
`define BLC_S_SS 2
`define BLC_S_CFGV 3
`define BLC_F_CFG 6:4
`define BLC_F_FSEL 10:8
`define BLC_F_ST 13:12
`define BLC_CLK_KHZ 100000
`define BLC_OSC_MHZ 20
`define BLC_OSC_DIV 3'h5
`define BLC_DISCH_MS 400
`define BLC_DISCH_CYC (`BLC_DISCH_MS * `BLC_CLK_KHZ)
`define BLC_SYNC_FMAX_KHZ 2222
`define BLC_SYNC_FMIN_KHZ 100
`define BLC_SYNC_PMIN (`BLC_CLK_KHZ / `BLC_SYNC_FMAX_KHZ)
`define BLC_SYNC_PMAX (`BLC_CLK_KHZ / `BLC_SYNC_FMIN_KHZ)
`define BLC_SYNC_TO_NS 20000
`define BLC_SYNC_TO_TICKS (`BLC_SYNC_TO_NS * `BLC_OSC_MHZ / 1000)
`define BLC_PWM_MASK 17'h1FFFF
`endif

// [logic/blc_pkg.sv]
// Types shared by the backlight control block
package blc_pkg;
    typedef enum logic [1:0] {ST_SHUT, ST_RUN, ST_DISCH, ST_FAULT} blc_pwr_e;
    typedef struct packed {
        logic ext_sync;
        logic ss_en;
        logic [1:0] span;
        logic [1:0] rate;
        logic [6:0] dev_tenths;
        logic [10:0] mod_hz;
    } blc_boost_clk_s;
    typedef struct packed {
        logic boost_run;
        logic sinks_en;
        logic fet_on;
        logic discharge_on;
    } blc_pwr_s;
    typedef logic [5:0][11:0] blc_cur_t;
endpackage

// [logic/blc_sync_det.sv]
// Boost sync pin classifier: external clock, static high or static low
`timescale 1ns/1ns
`include "blc_defs.svh"
module blc_sync_det (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic osc_tick,
    input wire logic boost_sync_input,
    output logic ext_mode,
    output logic ss_en
);
    logic in_r, seen_r, ext_r, ss_r, arm_r;
    logic in_nxt, seen_nxt, ext_nxt, ss_nxt, arm_nxt;
    logic [9:0] per_r, per_nxt, to_r, to_nxt;
    logic rise, edge_any, tmo, good;

    always_comb begin
        in_nxt = boost_sync_input;
        arm_nxt = 1'b1;
        // A pin held high through reset must not look like a fresh edge
        rise = boost_sync_input & ~in_r & arm_r;
        edge_any = (boost_sync_input ^ in_r) & arm_r;
        // Period in sys_clk cycles; the pin is synchronous already
        good = (per_r >= 10'(`BLC_SYNC_PMIN - 1)) && (per_r <= 10'(`BLC_SYNC_PMAX - 1));
        tmo = (to_r >= 10'(`BLC_SYNC_TO_TICKS));
        per_nxt = rise ? 10'h000 : ((&per_r) ? per_r : per_r + 10'h001);
        to_nxt = edge_any ? 10'h000 : ((osc_tick && !tmo) ? to_r + 10'h001 : to_r);
        seen_nxt = seen_r | rise;
        ext_nxt = ext_r;
        if (rise) begin
            ext_nxt = seen_r & good;
        end else if (tmo) begin
            ext_nxt = 1'b0;
        end
        // Spread only follows a level that has stayed still past the timeout
        ss_nxt = ~ext_nxt & tmo & ~edge_any & in_r;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            in_r <= 1'b0;
            arm_r <= 1'b0;
            seen_r <= 1'b0;
            ext_r <= 1'b0;
            ss_r <= 1'b0;
            per_r <= 10'h000;
            to_r <= 10'h000;
        end else begin
            in_r <= in_nxt;
            arm_r <= arm_nxt;
            seen_r <= seen_nxt;
            ext_r <= ext_nxt;
            ss_r <= ss_nxt;
            per_r <= per_nxt;
            to_r <= to_nxt;
        end
    end

    assign ext_mode = ext_r;
    assign ss_en = ss_r;

    ss_excl_a: assert property (@(posedge sys_clk) disable iff (srst)
        ext_r |-> !ss_r) else $error("spread active in sync mode");
    sync_lost_a: assert property (@(posedge sys_clk) disable iff (srst)
        (ext_r && tmo && !rise) |=> !ext_r) else $error("sync loss not taken");
endmodule

// [logic/blc_top.sv]
// Backlight driver control: boost clock, discharge, string setup, LED PWM
//
// Contract
// - Static high sync pin enables spread spectrum; static low keeps it off.
// - A 100-2222 kHz clock on sync pin selects external sync mode.
// - Sync clock lost: resistor frequency, spread follows the final pin level.
// - Spread spectrum is always off while externally synchronised.
// - Span field picks 3.3/4.3/5.3/7.2 percent deviation, 5.3 at reset.
// - Rate field picks 200/500/800/1200 Hz modulation, 200 at reset.
// - Enable low stops boost and sinks, opens FET, starts discharge.
// - Discharge lasts 400 ms, then the device shuts down.
// - Discharge pin over high threshold: fault recovery and high-OVP fault.
// - Light load conditions make the boost skip switching cycles.
// - Each string has a 12-bit current code, reset to full scale.
// - String setup sampled at power-on, held until shutdown.
// - Ungrouped 6/5/4/3/2 channels are spaced 60/72/90/120/180 degrees.
// - Pairs at 120, triples at 180, all six with no shift.
// - LED PWM clock from 20 MHz, eight rates 152 Hz to 19.531 kHz.
// - Brightness comes from the PWM input duty or a host register.
// - Steps per LED PWM period equal 20 MHz over the PWM rate.
`timescale 1ns/1ns
`include "blc_defs.svh"
module blc_top #(
    parameter int DISCH_CYCLES = `BLC_DISCH_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic en_pin,
    input wire logic boost_sync_input,
    input wire logic disch_ovp_high,
    input wire logic [2:0] light_load,
    input wire logic [2:0] string_config_resistor,
    input wire logic [2:0] dimming_freq_resistor,
    input wire logic [15:0] pwm_in_duty,
    output blc_pkg::blc_boost_clk_s boost_clk,
    output blc_pkg::blc_pwr_s pwr,
    output logic boost_overvoltage_high_fault,
    output logic fault_recovery,
    output logic pfm_skip,
    output blc_pkg::blc_cur_t string_current_code,
    output logic [5:0] sink_output
);
    import blc_pkg::*;

    // Span to deviation in tenths of a percent
    function automatic logic [6:0] span_dev(input logic [1:0] s);
        unique case (s)
            2'h0: span_dev = 7'h21;
            2'h1: span_dev = 7'h2B;
            2'h2: span_dev = 7'h35;
            2'h3: span_dev = 7'h48;
        endcase
    endfunction

    function automatic logic [10:0] rate_hz(input logic [1:0] r);
        unique case (r)
            2'h0: rate_hz = 11'h0C8;
            2'h1: rate_hz = 11'h1F4;
            2'h2: rate_hz = 11'h320;
            2'h3: rate_hz = 11'h4B0;
        endcase
    endfunction

    // Codes 0-4: 6..2 single channels; 5: pairs; 6: triples; 7: one group
    function automatic logic [2:0] grp_size(input logic [2:0] c);
        grp_size = (c == 3'h5) ? 3'h2 : (c == 3'h6) ? 3'h3 : (c == 3'h7) ? 3'h6 : 3'h1;
    endfunction

    function automatic logic [2:0] grp_count(input logic [2:0] c);
        grp_count = (c < 3'h5) ? 3'h6 - c : (c == 3'h5) ? 3'h3 : (c == 3'h6) ? 3'h2 : 3'h1;
    endfunction

    function automatic logic ch_active(input logic [2:0] c, input logic [2:0] ch);
        ch_active = (c >= 3'h5) || (ch < grp_count(c));
    endfunction

    // Start offset of a channel as a fraction of the PWM period
    function automatic logic [16:0] ch_phase(input logic [2:0] c, input logic [2:0] ch,
                                             input logic [16:0] mask);
        logic [20:0] per;
        logic [2:0] slot;
        per = {4'h0, mask} + 21'h1;
        slot = ch / grp_size(c);
        ch_phase = 17'((per * 21'(slot)) / 21'(grp_count(c)));
    endfunction

    function automatic logic cur_hit(input logic [7:0] a);
        cur_hit = (a >= `BLC_REG_CUR0) && (a <= `BLC_REG_CUR5) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] cur_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `BLC_REG_CUR0;
        cur_idx = d[4:2];
    endfunction

    logic ext_mode, ss_pin;
    logic [2:0] osc_div_r, osc_div_nxt;
    logic osc_tick;

    // 20 MHz oscillator tick from the 100 MHz system clock
    always_comb begin
        osc_tick = (osc_div_r == `BLC_OSC_DIV - 3'h1);
        osc_div_nxt = osc_tick ? 3'h0 : osc_div_r + 3'h1;
    end

    blc_sync_det u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .osc_tick(osc_tick),
        .boost_sync_input(boost_sync_input),
        .ext_mode(ext_mode),
        .ss_en(ss_pin)
    );

    // Register file
    logic [4:0] ctrl_r, ctrl_nxt;
    logic [15:0] brt_r, brt_nxt;
    blc_cur_t cur_r, cur_nxt;
    logic ovph_r, ovph_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    blc_pwr_e st_r, st_nxt;
    logic [2:0] cfg_r, cfg_nxt, fsel_r, fsel_nxt;
    logic cfgv_r, cfgv_nxt;
    logic [25:0] disch_r, disch_nxt;
    logic disch_done;
    blc_pwr_s pwr_r, pwr_nxt;
    blc_boost_clk_s bclk_r, bclk_nxt;
    logic pfm_r, pfm_nxt;
    logic wr_ctrl, wr_brt, wr_stat;

    always_comb begin
        wr_ctrl = reg_wr && (reg_addr == `BLC_REG_CTRL);
        wr_brt = reg_wr && (reg_addr == `BLC_REG_BRT);
        wr_stat = reg_wr && (reg_addr == `BLC_REG_STAT);
        ctrl_nxt = wr_ctrl ? reg_wdata[4:0] : ctrl_r;
        brt_nxt = wr_brt ? reg_wdata[15:0] : brt_r;
        cur_nxt = cur_r;
        if (reg_wr && cur_hit(reg_addr)) begin
            cur_nxt[cur_idx(reg_addr)] = reg_wdata[11:0];
        end
        // A new fault in the clearing cycle keeps the flag set
        ovph_nxt = disch_ovp_high | (ovph_r & ~(wr_stat & reg_wdata[`BLC_S_OVPH]));
        rdata_nxt = 32'h0;
        if (reg_rd) begin
            if (reg_addr == `BLC_REG_CTRL) begin
                rdata_nxt[4:0] = ctrl_r;
            end else if (reg_addr == `BLC_REG_BRT) begin
                rdata_nxt[15:0] = brt_r;
            end else if (cur_hit(reg_addr)) begin
                rdata_nxt[11:0] = cur_r[cur_idx(reg_addr)];
            end else if (reg_addr == `BLC_REG_STAT) begin
                rdata_nxt[`BLC_S_OVPH] = ovph_r;
                rdata_nxt[`BLC_S_EXT] = bclk_r.ext_sync;
                rdata_nxt[`BLC_S_SS] = bclk_r.ss_en;
                rdata_nxt[`BLC_S_CFGV] = cfgv_r;
                rdata_nxt[`BLC_F_CFG] = cfg_r;
                rdata_nxt[`BLC_F_FSEL] = fsel_r;
                rdata_nxt[`BLC_F_ST] = st_r;
            end
        end
    end

    // Power sequencing
    always_comb begin
        disch_done = (disch_r == 26'(DISCH_CYCLES - 1));
        st_nxt = st_r;
        disch_nxt = 26'h0;
        if (disch_ovp_high) begin
            st_nxt = ST_FAULT;
        end else begin
            unique case (st_r)
                ST_SHUT: if (en_pin) begin
                    st_nxt = ST_RUN;
                end
                ST_RUN: if (!en_pin) begin
                    st_nxt = ST_DISCH;
                end
                ST_DISCH: begin
                    disch_nxt = disch_r + 26'h1;
                    if (disch_done) begin
                        st_nxt = ST_SHUT;
                    end
                end
                // Recovery ends once the comparator clears; restart needs enable
                ST_FAULT: st_nxt = ST_SHUT;
            endcase
        end
        pwr_nxt.boost_run = (st_nxt == ST_RUN);
        pwr_nxt.sinks_en = (st_nxt == ST_RUN);
        pwr_nxt.fet_on = (st_nxt == ST_RUN);
        pwr_nxt.discharge_on = (st_nxt == ST_DISCH);
        pfm_nxt = pwr_nxt.boost_run && (light_load != 3'h0);
        // Resistor straps are caught once and only refreshed from shutdown
        cfgv_nxt = cfgv_r;
        cfg_nxt = cfg_r;
        fsel_nxt = fsel_r;
        if (!cfgv_r) begin
            cfgv_nxt = 1'b1;
            cfg_nxt = string_config_resistor;
            fsel_nxt = dimming_freq_resistor;
        end else if (st_r == ST_SHUT && !en_pin) begin
            cfgv_nxt = 1'b0;
        end
        bclk_nxt.ext_sync = ext_mode;
        bclk_nxt.ss_en = ss_pin & ~ext_mode;
        bclk_nxt.span = ctrl_r[`BLC_F_SPAN];
        bclk_nxt.rate = ctrl_r[`BLC_F_RATE];
        bclk_nxt.dev_tenths = span_dev(ctrl_r[`BLC_F_SPAN]);
        bclk_nxt.mod_hz = rate_hz(ctrl_r[`BLC_F_RATE]);
    end

    // LED PWM on 20 MHz ticks: period is 2^(17-sel) ticks, 152 Hz to 19.531 kHz
    logic [16:0] pcnt_r, pcnt_nxt, pmask, duty;
    logic [15:0] brt_sel;
    logic [5:0] sink_r, sink_nxt;

    always_comb begin
        pmask = `BLC_PWM_MASK >> fsel_r;
        pcnt_nxt = osc_tick ? ((pcnt_r + 17'h1) & pmask) : pcnt_r;
        brt_sel = ctrl_r[`BLC_F_BSRC] ? brt_r : pwm_in_duty;
        duty = 17'({brt_sel, 1'b0} >> fsel_r);
        for (int i = 0; i < `BLC_NCH; i++) begin
            sink_nxt[i] = pwr_r.sinks_en && ch_active(cfg_r, 3'(i))
                && (((pcnt_r - ch_phase(cfg_r, 3'(i), pmask)) & pmask) < duty);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            osc_div_r <= 3'h0;
            ctrl_r <= `BLC_CTRL_RST;
            brt_r <= `BLC_BRT_RST;
            cur_r <= {`BLC_NCH{`BLC_CUR_RST}};
            ovph_r <= 1'b0;
            rdata_r <= 32'h0;
            st_r <= ST_SHUT;
            disch_r <= 26'h0;
            pwr_r <= '0;
            pfm_r <= 1'b0;
            cfgv_r <= 1'b0;
            cfg_r <= 3'h0;
            fsel_r <= 3'h0;
            bclk_r <= '0;
            pcnt_r <= 17'h0;
            sink_r <= 6'h0;
        end else begin
            osc_div_r <= osc_div_nxt;
            ctrl_r <= ctrl_nxt;
            brt_r <= brt_nxt;
            cur_r <= cur_nxt;
            ovph_r <= ovph_nxt;
            rdata_r <= rdata_nxt;
            st_r <= st_nxt;
            disch_r <= disch_nxt;
            pwr_r <= pwr_nxt;
            pfm_r <= pfm_nxt;
            cfgv_r <= cfgv_nxt;
            cfg_r <= cfg_nxt;
            fsel_r <= fsel_nxt;
            bclk_r <= bclk_nxt;
            pcnt_r <= pcnt_nxt;
            sink_r <= sink_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign boost_clk = bclk_r;
    assign pwr = pwr_r;
    assign boost_overvoltage_high_fault = ovph_r;
    assign fault_recovery = (st_r == ST_FAULT);
    assign pfm_skip = pfm_r;
    assign string_current_code = cur_r;
    assign sink_output = sink_r;

    sequence ctrl_wr_s(logic [1:0] v, int lsb);
        wr_ctrl && (reg_wdata[lsb +: 2] == v);
    endsequence

    sequence disch_enter_s;
        (st_r == ST_RUN) && !en_pin && !disch_ovp_high ##1 (st_r == ST_DISCH);
    endsequence

    ext_no_ss_a: assert property (@(posedge sys_clk) disable iff (srst)
        boost_clk.ext_sync |-> !boost_clk.ss_en) else $error("spread on in sync mode");
    span_max_a: assert property (@(posedge sys_clk) disable iff (srst)
        ctrl_wr_s(2'h3, 0) |-> ##2 (boost_clk.dev_tenths == 7'h48))
        else $error("span 11 not 7.2 percent");
    rate_max_a: assert property (@(posedge sys_clk) disable iff (srst)
        ctrl_wr_s(2'h3, 2) |-> ##2 (boost_clk.mod_hz == 11'h4B0))
        else $error("rate 11 not 1200 Hz");
    disch_start_a: assert property (@(posedge sys_clk) disable iff (srst)
        disch_enter_s |-> pwr.discharge_on && !pwr.boost_run && !pwr.fet_on && !pwr.sinks_en)
        else $error("discharge entry outputs wrong");
    disch_end_a: assert property (@(posedge sys_clk) disable iff (srst)
        (st_r == ST_DISCH) && disch_done && !disch_ovp_high |=> (st_r == ST_SHUT) && !pwr.discharge_on)
        else $error("discharge did not end on time");
    disch_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        (st_r == ST_DISCH) && !disch_done && !disch_ovp_high |=> (st_r == ST_DISCH))
        else $error("discharge ended early");
    ovp_fault_a: assert property (@(posedge sys_clk) disable iff (srst)
        disch_ovp_high |=> fault_recovery && boost_overvoltage_high_fault)
        else $error("high ovp not reported");
    pfm_skip_a: assert property (@(posedge sys_clk) disable iff (srst)
        (light_load != 3'h0) && (st_r == ST_RUN) && en_pin && !disch_ovp_high |=> pfm_skip)
        else $error("light load without skipping");
    cur_reset_a: assert property (@(posedge sys_clk)
        srst |=> (string_current_code[5] == `BLC_CUR_RST)) else $error("current code reset");
    cfg_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        cfgv_r && (st_r != ST_SHUT) |=> $stable(cfg_r) && $stable(fsel_r))
        else $error("string setup changed while on");
    one_group_a: assert property (@(posedge sys_clk) disable iff (srst)
        (cfg_r == 3'h7) && cfgv_r |-> (sink_r == 6'h00) || (sink_r == 6'h3F))
        else $error("single group channels split");
endmodule

// [dv/blc_plant_model.sv]
// Far-side model: sync pin source, discharge comparator, load level and PWM input duty
`timescale 1ns/1ns
module blc_plant_model #(
    parameter int HALF = 50
) (
    input wire logic sys_clk,
    input wire logic clk_on,
    input wire logic idle_lvl,
    input wire logic ovp_req,
    input wire logic load_req,
    input wire logic [15:0] duty_req,
    output logic boost_sync_input,
    output logic disch_ovp_high,
    output logic [2:0] light_load,
    output logic [15:0] pwm_in_duty
);
    int cnt;
    // Outputs settle at the first edge, while the block is still in reset
    always @(posedge sys_clk) begin
        // 1 MHz sits well inside the sync window; a stopped clock settles to a static level
        if (clk_on) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                boost_sync_input <= ~boost_sync_input;
            end
        end else begin
            cnt <= 0;
            boost_sync_input <= idle_lvl;
        end
        disch_ovp_high <= ovp_req;
        // Any set bit marks light load, so a sparse pattern is used
        light_load <= load_req ? 3'h5 : 3'h0;
        pwm_in_duty <= duty_req;
    end
endmodule

// [dv/tb_blc_top.sv]
// Self-checking bench for the backlight control block
`timescale 1ns/1ns
`include "blc_defs.svh"
module tb_blc_top;
    import blc_pkg::*;
    localparam int DISCH = 50;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic en_pin = 1'b0;
    logic [2:0] cfg = 3'h0;
    logic [2:0] dim = 3'h7;
    logic sync_on = 1'b0;
    logic sync_idle = 1'b0;
    logic ovp_req = 1'b0;
    logic load_req = 1'b0;
    logic [15:0] duty_req = 16'h4000;
    logic boost_sync_input;
    logic disch_ovp_high;
    logic [2:0] light_load;
    logic [15:0] pwm_in_duty;
    blc_boost_clk_s boost_clk;
    blc_pwr_s pwr;
    logic boost_overvoltage_high_fault;
    logic fault_recovery;
    logic pfm_skip;
    blc_cur_t string_current_code;
    logic [5:0] sink_output;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    blc_top #(.DISCH_CYCLES(DISCH)) i_blc_top (.sys_clk(sys_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .en_pin(en_pin), .boost_sync_input(boost_sync_input),
        .disch_ovp_high(disch_ovp_high), .light_load(light_load),
        .string_config_resistor(cfg), .dimming_freq_resistor(dim),
        .pwm_in_duty(pwm_in_duty), .boost_clk(boost_clk), .pwr(pwr),
        .boost_overvoltage_high_fault(boost_overvoltage_high_fault),
        .fault_recovery(fault_recovery), .pfm_skip(pfm_skip),
        .string_current_code(string_current_code), .sink_output(sink_output));
    blc_plant_model i_blc_plant_model (.sys_clk(sys_clk), .clk_on(sync_on),
        .idle_lvl(sync_idle), .ovp_req(ovp_req), .load_req(load_req), .duty_req(duty_req),
        .boost_sync_input(boost_sync_input), .disch_ovp_high(disch_ovp_high),
        .light_load(light_load), .pwm_in_duty(pwm_in_duty));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic give_verdict;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Ceiling sits well above the roughly 50k cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    task automatic set_sync(input logic on, input logic lvl);
        @(posedge sys_clk);
        sync_on <= on;
        sync_idle <= lvl;
    endtask
    task automatic restart(input logic [2:0] c);
        @(posedge sys_clk);
        srst <= 1'b1;
        cfg <= c;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        en_pin <= 1'b1;
        idle(3);
    endtask
    task automatic wait_sink(input int ch, input logic lvl, output int t);
        int k;
        k = 0;
        while (sink_output[ch] !== lvl && k < 12000) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (k >= 12000) chk(32'h0, 32'h1);
        t = cyc;
    endtask
    // Period and high time of one channel, in sys_clk cycles
    task automatic measure(input int ch, output int per, output int hi, output int t2);
        int t, t0, t1;
        wait_sink(ch, 1'b0, t);
        wait_sink(ch, 1'b1, t0);
        wait_sink(ch, 1'b0, t1);
        wait_sink(ch, 1'b1, t2);
        per = t2 - t0;
        hi = t1 - t0;
    endtask
    initial begin
        logic [31:0] d;
        logic [31:0] devs [4];
        logic [31:0] mods [4];
        int per, hi, t2, t3, k, bad, ons;
        devs = '{32'h21, 32'h2B, 32'h35, 32'h48};
        mods = '{32'hC8, 32'h1F4, 32'h320, 32'h4B0};
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        idle(2);
        rdchk(`BLC_REG_CTRL, 32'h2);
        rdchk(`BLC_REG_BRT, 32'hFFFF);
        for (k = 0; k < 6; k++) begin
            rdchk(8'(`BLC_REG_CUR0 + 4 * k), 32'hFFF);
            chk(string_current_code[k], 32'hFFF);
        end
        rdchk(8'h40, 32'h0);
        chk(boost_clk.dev_tenths, 32'h35);
        chk(boost_clk.mod_hz, 32'hC8);
        for (k = 0; k < 16; k++) begin
            wr(`BLC_REG_CTRL, k);
            idle(2);
            chk(boost_clk.dev_tenths, devs[k % 4]);
            chk(boost_clk.mod_hz, mods[k / 4]);
            chk(boost_clk.span, k % 4);
            chk(boost_clk.rate, k / 4);
        end
        wr(8'h14, 32'hFA123);
        rdchk(8'h14, 32'h123);
        chk(string_current_code[3], 32'h123);
        idle(2200);
        chk(boost_clk.ss_en, 32'h0);
        set_sync(1'b0, 1'b1);
        idle(2200);
        chk(boost_clk.ss_en, 32'h1);
        chk(boost_clk.ext_sync, 32'h0);
        set_sync(1'b1, 1'b1);
        idle(1000);
        chk(boost_clk.ext_sync, 32'h1);
        chk(boost_clk.ss_en, 32'h0);
        rd(`BLC_REG_STAT, d);
        chk(d[`BLC_S_EXT], 32'h1);
        chk(d[`BLC_S_SS], 32'h0);
        wr(`BLC_REG_CTRL, 32'h3);
        idle(3);
        chk(boost_clk.ss_en, 32'h0);
        set_sync(1'b0, 1'b0);
        idle(1500);
        chk(boost_clk.ext_sync, 32'h1);
        idle(700);
        chk(boost_clk.ext_sync, 32'h0);
        chk(boost_clk.ss_en, 32'h0);
        set_sync(1'b1, 1'b1);
        idle(1000);
        set_sync(1'b0, 1'b1);
        idle(2200);
        chk(boost_clk.ss_en, 32'h1);
        @(posedge sys_clk);
        en_pin <= 1'b1;
        idle(3);
        chk(pwr, 32'hE);
        @(posedge sys_clk);
        load_req <= 1'b1;
        idle(3);
        chk(pfm_skip, 32'h1);
        @(posedge sys_clk);
        load_req <= 1'b0;
        cfg <= 3'h2;
        idle(3);
        chk(pfm_skip, 32'h0);
        rd(`BLC_REG_STAT, d);
        chk(d[13:3], 32'h2E1);
        @(posedge sys_clk);
        en_pin <= 1'b0;
        idle(1);
        chk(pwr, 32'h1);
        k = 0;
        while (pwr.discharge_on === 1'b1 && k < 1000) begin
            idle(1);
            k++;
        end
        chk(k, DISCH);
        rdchk(`BLC_REG_STAT, 32'h0704);
        @(posedge sys_clk);
        en_pin <= 1'b1;
        idle(3);
        @(posedge sys_clk);
        ovp_req <= 1'b1;
        idle(3);
        chk(fault_recovery, 32'h1);
        chk(boost_overvoltage_high_fault, 32'h1);
        @(posedge sys_clk);
        ovp_req <= 1'b0;
        idle(3);
        chk(fault_recovery, 32'h0);
        chk(boost_overvoltage_high_fault, 32'h1);
        wr(`BLC_REG_STAT, 32'h1);
        idle(2);
        chk(boost_overvoltage_high_fault, 32'h0);
        restart(3'h4);
        measure(0, per, hi, t2);
        chk(per, 5120);
        chk(hi, 1280);
        wait_sink(1, 1'b1, t3);
        chk(t3 - t2, 2560);
        chk(sink_output[5:2], 32'h0);
        wr(`BLC_REG_CTRL, 32'h12);
        wr(`BLC_REG_BRT, 32'h8000);
        measure(0, per, hi, t2);
        measure(0, per, hi, t2);
        chk(hi, 2560);
        restart(3'h7);
        bad = 0;
        ons = 0;
        repeat (5200) begin
            idle(1);
            if (sink_output !== 6'h00 && sink_output !== 6'h3F) bad++;
            if (sink_output === 6'h3F) ons++;
        end
        chk(bad, 0);
        chk(ons > 0, 32'h1);
        give_verdict();
    end
endmodule
